// ### src/flash_cmd_defines.svh
// Constants of the serial flash command block: opcodes, counts, sizes and times.
// Assumes a 100 MHz system clock that oversamples the serial link.
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH

`define OP_STATUS_READ     8'h05
`define OP_WRITE_ENABLE    8'h06
`define OP_BLOCK32_ERASE   8'h52
`define OP_BLOCK64_ERASE   8'hD8
`define OP_CHIP_ERASE_A    8'h60
`define OP_CHIP_ERASE_B    8'hC7
`define OP_DEEP_SLEEP      8'hB9
`define OP_WAKE_ID         8'hAB
`define OP_MAKER_DEVICE_ID 8'h90
`define OP_JEDEC_ID        8'h9F
`define OP_UNIQUE_ID       8'h4B

`define OP_LAST            5'h07
`define ADDR_LAST          5'h17
`define DUMMY_LAST         5'h07

`define LAST_STATUS        7'h07
`define LAST_DEVICE        7'h07
`define LAST_MAKER_DEV     7'h0F
`define LAST_JEDEC         7'h17
`define LAST_UNIQUE        7'h7F

`define CLK_MHZ              100
`define BLOCK_ERASE_TIME_US  1000
`define CHIP_ERASE_TIME_US   4000
`define SLEEP_ENTRY_DELAY_NS 3000
`define WAKE_DELAY_NS        3000
`define WAKE_ID_DELAY_NS     2000

`define BLOCK32_BYTES      25'h0008000
`define BLOCK64_BYTES      25'h0010000
`define ARRAY_BYTES        25'h0100000

`define STAT_WIP_BIT       0
`define STAT_WEL_BIT       1
`define STAT_BP_LSB        2
`define ERASED_BYTE        8'hFF
`define WEL_RESET          1'b0
`define WIP_RESET          1'b0
`define JOB_FIFO_DEPTH     16

`endif

// ### src/flash_cmd_pkg.sv
// Types shared by the serial flash command block and its job queue.
// Assumes nothing beyond a SystemVerilog tool.
package flash_cmd_pkg;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
  } link_pins_t;

  typedef enum logic [1:0] {
    JOB_BLOCK32 = 2'h0,
    JOB_BLOCK64 = 2'h1,
    JOB_CHIP    = 2'h2
  } job_kind_t;

  typedef struct packed {
    job_kind_t   kind;
    logic [23:0] base;
    logic [7:0]  fill;
  } erase_job_t;

  typedef enum logic [5:0] {
    F_OP    = 6'h01,
    F_ADDR  = 6'h02,
    F_DUMMY = 6'h04,
    F_OUT   = 6'h08,
    F_DONE  = 6'h10,
    F_IGN   = 6'h20
  } frame_st_t;

  typedef enum logic [3:0] {
    P_ON    = 4'h1,
    P_ENTER = 4'h2,
    P_SLEEP = 4'h4,
    P_WAKE  = 4'h8
  } power_st_t;

endpackage : flash_cmd_pkg

// ### src/serial_flash_erase_power_id_cmds.sv
// Command logic of a serial flash: erase, deep sleep and identification reads.
// Assumes a host on the serial pins and an array agent draining erase jobs.
`include "flash_cmd_defines.svh"

// Shift-register queue: the head always sits in entry 0, so it is a flop.
module erase_job_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH+1];
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic [CW-1:0]    wr_idx;
  logic             push;
  logic             pop;

  // A push is refused while full even if a pop frees a slot this cycle.
  assign push    = i_in_valid && o_in_ready;
  assign pop     = o_out_valid && i_out_ready;
  assign wr_idx  = pop ? cnt_r - CW'(1) : cnt_r;
  assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  assign mem_r[DEPTH] = '0;

  // Each entry shifts down on a pop and takes the new word at its index.
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        mem_r[i] <= '0;
      end else if (push && wr_idx == CW'(i)) begin
        mem_r[i] <= i_in_data;
      end else if (pop) begin
        mem_r[i] <= mem_r[i+1];
      end
    end
  end

  // Count and the flags that face both sides.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_r       <= '0;
      o_out_valid <= 1'b0;
      o_in_ready  <= 1'b1;
    end else begin
      cnt_r       <= cnt_nxt;
      o_out_valid <= cnt_nxt != '0;
      o_in_ready  <= cnt_nxt != CW'(DEPTH);
    end
  end

  assign o_out_data = mem_r[0];
endmodule // erase_job_fifo

// How it works
// - 52H block erase needs write enable set.
// - D8H block erase needs write enable set.
// - Erase aligned block, ignore low offset bits.
// - Select rising off-boundary discards block erase.
// - Erase sets busy, clears enable, busy ends.
// - Protected block erase is not executed.
// - Chip erase 60H or C7H needs enable.
// - Chip erase only if select rises after opcode.
// - Chip erase only with all protect bits zero.
// - B9H enters deep sleep after entry delay.
// - Deep sleep ignores all but wake command.
// - Deep sleep refused during busy cycle.
// - Reset always leaves device in standby.
// - Plain wake waits wake delay before commands.
// - Wake with dummies repeats device ID MSB first.
// - ID form of wake uses second delay.
// - Wake command ignored while busy.
// - 90H gives maker/device or device first.
// - 9FH gives maker, type, capacity bytes.
// - JEDEC read not decoded while busy.
// - Select rising ends JEDEC read anytime.
// - 4BH with address and dummy gives 128 bits.
// - Status read answers in standby, even while busy.
// - Input bits sampled on rising edge, MSB first.
module serial_flash_erase_power_id_cmds
  import flash_cmd_pkg::*;
#(
  parameter int           BLOCK_ERASE_TIME_US = `BLOCK_ERASE_TIME_US,
  parameter int           CHIP_ERASE_TIME_US  = `CHIP_ERASE_TIME_US,
  parameter logic [7:0]   MAKER_ID            = 8'h5A, // Arbitrary value.
  parameter logic [7:0]   DEVICE_ID           = 8'h11, // Arbitrary value.
  parameter logic [7:0]   MEMORY_TYPE         = 8'h22, // Arbitrary value.
  parameter logic [7:0]   CAPACITY_CODE       = 8'h33, // Arbitrary value.
  parameter logic [127:0] UNIQUE_ID           = 128'h0123456789ABCDEF0F1E2D3C4B5A6978 // Arbitrary value.
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_si,
  output logic            o_so,
  output logic            o_so_oe,
  input  wire logic [2:0] i_block_protect_bits,
  output logic            o_write_in_progress_flag,
  output logic            o_write_enable_latch,
  output logic            o_deep_sleep,
  output logic            o_job_valid,
  input  wire logic       i_job_ready,
  output erase_job_t      o_job
);
  localparam int BLOCK_CYC = BLOCK_ERASE_TIME_US * `CLK_MHZ;
  localparam int CHIP_CYC  = CHIP_ERASE_TIME_US * `CLK_MHZ;
  localparam int SLEEP_CYC = (`SLEEP_ENTRY_DELAY_NS * `CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYC  = (`WAKE_DELAY_NS * `CLK_MHZ + 999) / 1000;
  localparam int WAKE2_CYC = (`WAKE_ID_DELAY_NS * `CLK_MHZ + 999) / 1000;

  link_pins_t  pin_s1_r;
  link_pins_t  pin_s2_r;
  link_pins_t  pin_s3_r;
  link_pins_t  pin_f_r;
  link_pins_t  pin_p_r;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  logic        cs_f;
  logic        si_f;
  frame_st_t   fst_r;
  frame_st_t   op_st;
  power_st_t   pwr_r;
  logic [4:0]  cnt_r;
  logic [22:0] sh_r;
  logic [7:0]  op_r;
  logic [7:0]  op_in;
  logic [7:0]  cur_op;
  logic [23:0] addr_r;
  logic [23:0] addr_in;
  logic [127:0] obuf_r;
  logic [127:0] nbuf;
  logic [6:0]  idx_r;
  logic [6:0]  last_r;
  logic [6:0]  nlast;
  logic        out_load;
  logic [7:0]  stat;
  logic        wel_r;
  logic        wip_r;
  logic [31:0] timer_r;
  logic [15:0] pcnt_r;
  logic        exec;
  logic        blk_cmd;
  logic        chip_cmd;
  logic        erase_go;
  logic        prot_hit;
  logic [24:0] blk_size;
  logic [24:0] blk_base;
  logic [24:0] blk_end;
  logic [24:0] prot_size;
  logic        fifo_ready;
  erase_job_t  job;

  // Three-flop pin sampling; a level counts once stages two and three agree.
  for (genvar i = 0; i < 3; i++) begin : g_pin
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        pin_s1_r[i] <= 1'b1;
        pin_s2_r[i] <= 1'b1;
        pin_s3_r[i] <= 1'b1;
        pin_f_r[i]  <= 1'b1;
        pin_p_r[i]  <= 1'b1;
      end else begin
        pin_s1_r[i] <= (i == 0) ? i_si : (i == 1) ? i_cs_n : i_sclk;
        pin_s2_r[i] <= pin_s1_r[i];
        pin_s3_r[i] <= pin_s2_r[i];
        if (pin_s2_r[i] == pin_s3_r[i]) begin
          pin_f_r[i] <= pin_s3_r[i];
        end
        pin_p_r[i] <= pin_f_r[i];
      end
    end
  end

  assign cs_f      = pin_f_r.cs_n;
  assign si_f      = pin_f_r.si;
  assign sclk_rise = pin_f_r.sclk && !pin_p_r.sclk;
  assign sclk_fall = !pin_f_r.sclk && pin_p_r.sclk;
  assign cs_rise   = pin_f_r.cs_n && !pin_p_r.cs_n;
  assign op_in     = {sh_r[6:0], si_f};
  assign addr_in   = {sh_r[22:0], si_f};
  assign cur_op    = (fst_r == F_OP) ? op_in : op_r;

  // Live status byte; upper bits are not kept by this block.
  // status byte layout
  assign stat = {3'h0, i_block_protect_bits, wel_r, wip_r};

  // Opcode decode at the eighth bit decides the rest of the frame.
  always_comb begin
    op_st = F_IGN;
    if (pwr_r == P_ON || (pwr_r == P_SLEEP && op_in == `OP_WAKE_ID)) begin
      case (op_in)
        `OP_STATUS_READ:     op_st = F_OUT;
        `OP_JEDEC_ID:        op_st = wip_r ? F_IGN : F_OUT;
        `OP_WAKE_ID:         op_st = wip_r ? F_IGN : F_ADDR;
        `OP_BLOCK32_ERASE,
        `OP_BLOCK64_ERASE,
        `OP_MAKER_DEVICE_ID,
        `OP_UNIQUE_ID:       op_st = F_ADDR;
        `OP_WRITE_ENABLE,
        `OP_CHIP_ERASE_A,
        `OP_CHIP_ERASE_B,
        `OP_DEEP_SLEEP:      op_st = F_DONE;
        default:             op_st = F_IGN;
      endcase
    end
  end

  // Frame sequencing; every frame restarts while select is high.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fst_r  <= F_OP;
      cnt_r  <= 5'h00;
      sh_r   <= 23'h000000;
      op_r   <= 8'h00;
      addr_r <= 24'h000000;
    end else if (cs_f) begin
      fst_r <= F_OP;
      cnt_r <= 5'h00;
    end else if (sclk_rise) begin
      sh_r  <= addr_in[22:0];
      cnt_r <= cnt_r + 5'h01;
      case (fst_r)
        F_OP: begin
          if (cnt_r == `OP_LAST) begin
            op_r  <= op_in;
            cnt_r <= 5'h00;
            fst_r <= op_st;
          end
        end
        F_ADDR: begin
          if (cnt_r == `ADDR_LAST) begin
            addr_r <= addr_in;
            cnt_r  <= 5'h00;
            if (op_r == `OP_BLOCK32_ERASE || op_r == `OP_BLOCK64_ERASE) begin
              fst_r <= F_DONE;
            end else if (op_r == `OP_UNIQUE_ID) begin
              fst_r <= F_DUMMY;
            end else begin
              fst_r <= F_OUT;
            end
          end
        end
        F_DUMMY: begin
          if (cnt_r == `DUMMY_LAST) begin
            fst_r <= F_OUT;
          end
        end
        F_DONE: fst_r <= F_IGN;
        default: fst_r <= fst_r;
      endcase
    end
  end

  // The output buffer is loaded on the rising edge that ends the input.
  assign out_load = sclk_rise && !cs_f &&
    ((fst_r == F_OP && cnt_r == `OP_LAST && op_st == F_OUT) ||
     (fst_r == F_ADDR && cnt_r == `ADDR_LAST && op_r != `OP_BLOCK32_ERASE &&
      op_r != `OP_BLOCK64_ERASE && op_r != `OP_UNIQUE_ID) ||
     (fst_r == F_DUMMY && cnt_r == `DUMMY_LAST));

  // Answer contents per opcode, right-aligned in the buffer.
  always_comb begin
    nbuf  = 128'h0;
    nlast = `LAST_DEVICE;
    case (cur_op)
      `OP_STATUS_READ: begin
        nbuf  = {120'h0, stat};
        nlast = `LAST_STATUS;
      end
      `OP_JEDEC_ID: begin
        nbuf  = {104'h0, MAKER_ID, MEMORY_TYPE, CAPACITY_CODE};
        nlast = `LAST_JEDEC;
      end
      `OP_MAKER_DEVICE_ID: begin
        nbuf  = addr_in[0] ? {112'h0, DEVICE_ID, MAKER_ID} : {112'h0, MAKER_ID, DEVICE_ID};
        nlast = `LAST_MAKER_DEV;
      end
      `OP_UNIQUE_ID: begin
        nbuf  = UNIQUE_ID;
        nlast = `LAST_UNIQUE;
      end
      default: begin
        nbuf  = {120'h0, DEVICE_ID};
        nlast = `LAST_DEVICE;
      end
    endcase
  end

  // Serial output on falling edges; the index wraps so answers repeat.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      obuf_r  <= 128'h0;
      idx_r   <= 7'h00;
      last_r  <= 7'h00;
      o_so    <= 1'b0;
      o_so_oe <= 1'b0;
    end else begin
      o_so_oe <= !cs_f && fst_r == F_OUT;
      if (out_load) begin
        obuf_r <= nbuf;
        last_r <= nlast;
        idx_r  <= nlast;
      end else if (sclk_fall && !cs_f && fst_r == F_OUT) begin
        o_so  <= (op_r == `OP_STATUS_READ) ? stat[idx_r[2:0]] : obuf_r[idx_r];
        idx_r <= (idx_r == 7'h00) ? last_r : idx_r - 7'h01;
      end
    end
  end

  // Block geometry and protected region at the top of the array.
  always_comb begin
    blk_size  = (op_r == `OP_BLOCK64_ERASE) ? `BLOCK64_BYTES : `BLOCK32_BYTES;
    blk_base  = {1'b0, addr_r} & ~(blk_size - 25'h0000001);
    blk_end   = blk_base + blk_size;
    prot_size = (i_block_protect_bits == 3'h0) ? 25'h0000000 :
                (`ARRAY_BYTES >> (3'h7 - i_block_protect_bits));
    prot_hit  = (i_block_protect_bits != 3'h0) && (blk_end > `ARRAY_BYTES - prot_size);
  end

  assign exec     = cs_rise && fst_r == F_DONE;
  assign blk_cmd  = exec && (op_r == `OP_BLOCK32_ERASE || op_r == `OP_BLOCK64_ERASE);
  assign chip_cmd = exec && (op_r == `OP_CHIP_ERASE_A || op_r == `OP_CHIP_ERASE_B);
  assign erase_go = wel_r && !wip_r && fifo_ready &&
                    ((blk_cmd && !prot_hit) || (chip_cmd && i_block_protect_bits == 3'h0));

  // Job for the array agent; a full queue refuses the erase like a protect hit.
  always_comb begin
    job.kind = chip_cmd ? JOB_CHIP : (op_r == `OP_BLOCK64_ERASE) ? JOB_BLOCK64 : JOB_BLOCK32;
    job.base = chip_cmd ? 24'h000000 : blk_base[23:0];
    job.fill = `ERASED_BYTE;
  end

  // Self-timed cycle and enable latch.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wel_r   <= `WEL_RESET;
      wip_r   <= `WIP_RESET;
      timer_r <= 32'h00000000;
    end else begin
      if (erase_go) begin
        wip_r   <= 1'b1;
        wel_r   <= 1'b0;
        timer_r <= chip_cmd ? 32'(CHIP_CYC - 1) : 32'(BLOCK_CYC - 1);
      end else begin
        if (exec && op_r == `OP_WRITE_ENABLE && !wip_r) begin
          wel_r <= 1'b1;
        end
        if (wip_r) begin
          if (timer_r == 32'h00000000) begin
            wip_r <= 1'b0;
          end else begin
            timer_r <= timer_r - 32'h00000001;
          end
        end
      end
    end
  end

  // Power mode; reset stands for power-up, so it always lands in standby.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pwr_r  <= P_ON;
      pcnt_r <= 16'h0000;
    end else begin
      case (pwr_r)
        P_ON: begin
          if (exec && op_r == `OP_DEEP_SLEEP && !wip_r) begin
            pwr_r  <= P_ENTER;
            pcnt_r <= 16'(SLEEP_CYC - 1);
          end
        end
        P_ENTER: begin
          if (pcnt_r == 16'h0000) begin
            pwr_r <= P_SLEEP;
          end else begin
            pcnt_r <= pcnt_r - 16'h0001;
          end
        end
        P_SLEEP: begin
          if (cs_rise && op_r == `OP_WAKE_ID && fst_r == F_ADDR && cnt_r == 5'h00) begin
            pwr_r  <= P_WAKE;
            pcnt_r <= 16'(WAKE_CYC - 1);
          end else if (cs_rise && op_r == `OP_WAKE_ID && fst_r == F_OUT) begin
            pwr_r  <= P_WAKE;
            pcnt_r <= 16'(WAKE2_CYC - 1);
          end
        end
        P_WAKE: begin
          if (pcnt_r == 16'h0000) begin
            pwr_r <= P_ON;
          end else begin
            pcnt_r <= pcnt_r - 16'h0001;
          end
        end
        default: pwr_r <= P_ON;
      endcase
    end
  end

  // Registered status outputs.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_write_in_progress_flag <= 1'b0;
      o_write_enable_latch     <= 1'b0;
      o_deep_sleep             <= 1'b0;
    end else begin
      o_write_in_progress_flag <= wip_r;
      o_write_enable_latch     <= wel_r;
      o_deep_sleep             <= pwr_r == P_SLEEP;
    end
  end

  erase_job_fifo #(
    .WIDTH ($bits(erase_job_t)),
    .DEPTH (`JOB_FIFO_DEPTH)
  ) u_jobs (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_in_valid  (erase_go),
    .o_in_ready  (fifo_ready),
    .i_in_data   (job),
    .o_out_valid (o_job_valid),
    .i_out_ready (i_job_ready),
    .o_out_data  (o_job)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_enter;
    $rose(pwr_r == P_ENTER);
  endsequence

  sequence s_wake;
    $rose(pwr_r == P_WAKE);
  endsequence

  busy_start_a: assert property ($rose(wip_r) |-> $past(wel_r) && !wel_r)
    else $error("busy started without enable or enable kept");
  enable_gate_a: assert property (erase_go |=> wip_r ##1 o_write_in_progress_flag)
    else $error("accepted erase did not raise busy");
  block_align_a: assert property (erase_go && job.kind == JOB_BLOCK64 |-> job.base[15:0] == 16'h0000)
    else $error("64KB erase base not aligned");
  protect_block_a: assert property (erase_go && job.kind != JOB_CHIP |-> blk_end <= `ARRAY_BYTES - prot_size)
    else $error("protected block erased");
  chip_protect_a: assert property (erase_go && job.kind == JOB_CHIP |-> i_block_protect_bits == 3'h0)
    else $error("chip erase with protection set");
  sleep_busy_a: assert property (s_enter |-> $past(!wip_r))
    else $error("sleep entered during busy cycle");
  sleep_entry_a: assert property (s_enter |-> ##299 (pwr_r == P_ENTER) ##1 (pwr_r == P_SLEEP))
    else $error("sleep entry delay wrong");
  sleep_quiet_a: assert property (pwr_r == P_SLEEP |=> !$rose(wip_r) && !$rose(wel_r))
    else $error("command acted during sleep");
  wake_hold_a: assert property (s_wake |-> (pwr_r == P_WAKE) [*8] ##[1:400] pwr_r == P_ON)
    else $error("wake delay wrong");
  select_end_a: assert property ($rose(cs_f) |=> !o_so_oe)
    else $error("output driven after select rose");
endmodule // serial_flash_erase_power_id_cmds

// ### tb/spi_host_model.sv
// Host model that frames commands on the serial pins of the flash command block.
// Assumes the bench calls xfer between frames and reads the answer it returns.
module spi_host_model (
  input  wire logic i_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_si,
  output logic      o_oe_seen
);
  timeunit 1ns;
  timeprecision 1ns;

  // The serial clock stands low outside frames.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_oe_seen = 1'b0;
  end

  // One frame: opcode, then n_in bits from the top of arg, then n_out bits read back.
  task automatic xfer(input logic [7:0] op, input int n_in, input logic [31:0] arg,
                      input int n_out, output logic [127:0] rx);
    logic [39:0] sh;
    sh = {op, arg};
    rx = '0;
    o_oe_seen = 1'b0;
    @(posedge i_clk);
    #1 o_cs_n = 1'b0;
    for (int k = 0; k < 8 + n_in; k++) begin
      o_si = sh[39-k];
      #80 o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
    end
    // The answer is taken at the rising edge, long after the device changed it.
    for (int k = 0; k < n_out; k++) begin
      #80 o_sclk = 1'b1;
      rx = {rx[126:0], i_so};
      o_oe_seen = o_oe_seen | i_so_oe;
      #80 o_sclk = 1'b0;
    end
    #80 o_cs_n = 1'b1;
    // A released data line shows the inverse of its last value.
    o_si = ~o_si;
    #200;
  endtask
endmodule // spi_host_model

// ### tb/serial_flash_erase_power_id_cmds_bench.sv
// Self-checking bench for the flash command block and its job queue.
// Assumes the defines header is on the include path and the host model frames commands.
`include "flash_cmd_defines.svh"
module serial_flash_erase_power_id_cmds_bench import flash_cmd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic         i_clk = 1'b0;
  logic         i_reset = 1'b1;
  logic [2:0]   bp = 3'h0;
  logic         job_ready = 1'b0;
  logic         sclk, cs_n, si, so, so_oe, oe_seen, write_in_progress_flag, write_enable_latch, sleep, job_valid;
  erase_job_t   job;
  logic [127:0] rx;
  int           err_total = 0, num_checks = 0, cycles = 0;
  logic [7:0]   ops [4] = '{`OP_BLOCK32_ERASE, `OP_BLOCK64_ERASE, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B};
  logic [31:0]  args [4] = '{32'h01234500, 32'h0ABCDE00, 32'h0, 32'h0};
  logic [33:0]  jexp [4] = '{{JOB_BLOCK32, 24'h010000, 8'hFF}, {JOB_BLOCK64, 24'h0A0000, 8'hFF},
                           {JOB_CHIP, 24'h0, 8'hFF}, {JOB_CHIP, 24'h0, 8'hFF}};
  logic [7:0]   id_op [6] = '{`OP_JEDEC_ID, `OP_JEDEC_ID, `OP_MAKER_DEVICE_ID, `OP_MAKER_DEVICE_ID,
                            `OP_WAKE_ID, `OP_UNIQUE_ID};
  int           id_in [6] = '{0, 0, 24, 24, 24, 32};
  int           id_out [6] = '{8, 24, 16, 16, 16, 128};
  logic [31:0]  id_arg [6] = '{32'h0, 32'h0, 32'h0, 32'h100, 32'h0, 32'h0};
  logic [127:0] id_exp [6] = '{8'h5A, 24'h5A2233, 16'h5A11, 16'h115A, 16'h1111,
                             128'h0123456789ABCDEF0F1E2D3C4B5A6978};

  always #5 i_clk = ~i_clk;

  serial_flash_erase_power_id_cmds #(.BLOCK_ERASE_TIME_US(10), .CHIP_ERASE_TIME_US(30))
    i_serial_flash_erase_power_id_cmds (.i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_block_protect_bits(bp), .o_write_in_progress_flag(write_in_progress_flag),
    .o_write_enable_latch(write_enable_latch), .o_deep_sleep(sleep), .o_job_valid(job_valid), .i_job_ready(job_ready),
    .o_job(job));

  spi_host_model i_spi_host_model (.i_clk(i_clk), .i_so(so), .i_so_oe(so_oe), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_si(si), .o_oe_seen(oe_seen));

  // Every result is compared as four-state bits, so an unknown never matches.
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] op, input int n_in, input logic [31:0] arg, input int n_out);
    i_spi_host_model.xfer(op, n_in, arg, n_out, rx);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Bounded wait for the self-timed cycle to end.
  task automatic wait_idle();
    for (int k = 0; k < 4000 && write_in_progress_flag !== 1'b0; k++) wait_cyc(1);
    chk(write_in_progress_flag, 1'b0);
  endtask

  // Check the queued job under a mask, then pop it and see the queue empty.
  task automatic take_job(input logic [33:0] exp, input logic [33:0] mask);
    chk(job_valid, 1'b1);
    chk(job & mask, exp);
    job_ready = 1'b1;
    wait_cyc(1);
    job_ready = 1'b0;
    wait_cyc(1);
    chk(job_valid, 1'b0);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The whole run needs roughly 50000 cycles, so this ceiling only catches a hang.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 90000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    wait_cyc(2);
    i_reset = 1'b0;
    wait_cyc(6);
    chk({write_in_progress_flag, write_enable_latch, sleep, job_valid, so_oe}, 5'h00); // Standby after reset.
    bp = 3'h5;
    cmd(`OP_STATUS_READ, 0, 0, 8);
    chk(rx, 8'h14); // Status shows the protect bits.
    bp = 3'h0;
    cmd(`OP_BLOCK32_ERASE, 24, args[0], 0);
    chk({write_in_progress_flag, job_valid}, 2'b00); // Erase without enable dropped.
    $display("Test reset_status done");
    for (int k = 0; k < 4; k++) begin
      cmd(`OP_WRITE_ENABLE, 0, 0, 0);
      chk(write_enable_latch, 1'b1); // Enable latch set.
      cmd(ops[k], (k < 2) ? 24 : 0, args[k], 0);
      chk({write_in_progress_flag, write_enable_latch}, 2'b10); // Busy set, enable cleared.
      take_job(jexp[k], (k < 2) ? 34'h3FFFFFFFF : 34'h3000000FF); // Aligned base.
      if (k == 0) begin
        cmd(`OP_STATUS_READ, 0, 0, 8);
        chk(rx, 8'h01); // Status answered while busy.
        cmd(`OP_DEEP_SLEEP, 0, 0, 0);
        cmd(`OP_JEDEC_ID, 0, 0, 24);
        chk(oe_seen, 1'b0); // Identity read not decoded while busy.
      end
      wait_idle(); // Busy clears at the end.
      chk(sleep, 1'b0); // Sleep refused while busy.
    end
    $display("Test erase_accept done");
    cmd(`OP_WRITE_ENABLE, 0, 0, 0);
    cmd(`OP_BLOCK32_ERASE, 25, args[0], 0);
    chk({write_in_progress_flag, job_valid, write_enable_latch}, 3'b001); // Extra clock discards erase.
    bp = 3'h1;
    cmd(`OP_BLOCK64_ERASE, 24, 32'h0F000000, 0);
    chk({write_in_progress_flag, job_valid, write_enable_latch}, 3'b001); // Protected block kept.
    cmd(`OP_CHIP_ERASE_A, 0, 0, 0);
    chk({write_in_progress_flag, job_valid, write_enable_latch}, 3'b001); // Chip erase needs no protection.
    bp = 3'h0;
    cmd(`OP_CHIP_ERASE_B, 1, 0, 0);
    chk({write_in_progress_flag, job_valid, write_enable_latch}, 3'b001); // Late select rise discards.
    $display("Test erase_refuse done");
    for (int k = 0; k < 6; k++) begin
      cmd(id_op[k], id_in[k], id_arg[k], id_out[k]);
      chk(rx, id_exp[k]); // Identity bytes MSB first.
    end
    $display("Test id_reads done");
    cmd(`OP_WAKE_ID, 0, 0, 0);
    cmd(`OP_DEEP_SLEEP, 0, 0, 0);
    wait_cyc(320);
    chk(sleep, 1'b1); // Sleep after the entry delay.
    cmd(`OP_BLOCK32_ERASE, 24, args[0], 0);
    cmd(`OP_STATUS_READ, 0, 0, 8);
    chk({oe_seen, write_in_progress_flag, job_valid}, 3'b000); // Commands ignored asleep.
    cmd(`OP_WAKE_ID, 0, 0, 0);
    wait_cyc(320); // Select held high through the wake delay.
    chk(sleep, 1'b0); // Awake after the delay.
    cmd(`OP_STATUS_READ, 0, 0, 8);
    chk(rx, 8'h02); // Commands accepted after the wake delay.
    cmd(`OP_DEEP_SLEEP, 0, 0, 0);
    wait_cyc(320);
    cmd(`OP_WAKE_ID, 24, 0, 8);
    chk(rx, 8'h11); // Identity given on wake.
    wait_cyc(220); // Select held high through the shorter delay.
    cmd(`OP_STATUS_READ, 0, 0, 8);
    chk({sleep, rx[7:0]}, 9'h002); // Normal again, enable kept.
    $display("Test power done");
    // Sixteen erases fill the job queue while nobody drains it; the seventeenth is refused.
    for (int k = 0; k < 17; k++) begin
      cmd(`OP_WRITE_ENABLE, 0, 0, 0);
      cmd(`OP_BLOCK32_ERASE, 24, 32'(k) << 23, 0);
      chk({write_in_progress_flag, write_enable_latch}, {k < 16, k >= 16}); // Queued until full, then refused.
      wait_idle();
    end
    job_ready = 1'b1;
    for (int k = 0; k < 16; k++) begin
      chk({job_valid, job}, {1'b1, JOB_BLOCK32, 24'(k << 15), 8'hFF}); // Drained in order.
      wait_cyc(1);
    end
    job_ready = 1'b0;
    chk(job_valid, 1'b0); // Queue empty.
    $display("Test job_queue done");
    end_of_test();
  end
endmodule // serial_flash_erase_power_id_cmds_bench
